/* include/swrc_defs.vh */
// Constants for the sleep, wake and reset control block
`ifndef SWRC_DEFS_VH
`define SWRC_DEFS_VH
// Register byte addresses
`define SWRC_ADR_XCFG 4'h0
`define SWRC_ADR_STAT 4'h4
`define SWRC_ADR_CTRL 4'h8
`define SWRC_ADR_TMR 4'hc
// extra_config_register fields
`define SWRC_XCFG_WAKE_EN 0
`define SWRC_XCFG_BO_EN_N 1
`define SWRC_XCFG_BO_SEL3V 2
`define SWRC_XCFG_SL 3
`define SWRC_XCFG_SWDT 4
`define SWRC_XCFG_RST 8'h02
// Status fields
`define SWRC_STAT_PIN_CHANGE_WAKE_FLAG 0
`define SWRC_STAT_SLEEP 1
`define SWRC_STAT_CORE_RST 2
`define SWRC_STAT_WDT_ON 3
`define SWRC_STAT_BO_LVL 4
// Control register fields
`define SWRC_CTRL_SLEEP 0
`define SWRC_CTRL_PRESC 3:1
`define SWRC_CTRL_RST 4'h0
// Start-up times in microseconds and derived cycle counts at 200 MHz
`define SWRC_CLK_MHZ 200
`define SWRC_START_RC_US 1000
`define SWRC_START_STD_US 18000
`define SWRC_START_RC_CYC (`SWRC_START_RC_US * `SWRC_CLK_MHZ)
`define SWRC_START_STD_CYC (`SWRC_START_STD_US * `SWRC_CLK_MHZ)
// Glitch filter length in cycles
`define SWRC_FILT_CYC 3'h4
`endif

/* design/swrc_sync.v */
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
module swrc_sync
(
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Pin in, synchronised level out
   input wire pin_i,
   output reg sync_o
);
   reg meta;

   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta <= pin_i;
         sync_o <= meta;
      end
   end
endmodule // swrc_sync

/* design/swrc_filt.v */
// Glitch filter: output follows input only after it stays stable
`timescale 1ns/1ps
`include "swrc_defs.vh"
module swrc_filt
#(
   parameter RST_VAL = 1'b0
)
(
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Synchronised level in, filtered level out
   input wire in_i,
   output reg out_o
);
   reg [2:0] cnt;

   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt <= 3'h0;
         out_o <= RST_VAL;
      end
      else if (in_i == out_o)
      begin
         cnt <= 3'h0;
      end
      else if (cnt == `SWRC_FILT_CYC - 3'h1)
      begin
         cnt <= 3'h0;
         out_o <= in_i;
      end
      else
      begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule // swrc_filt

/* design/swrc_top.v */
// Sleep, wake and reset supervision with Wishbone register access
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "swrc_defs.vh"
module swrc_top
#(
   parameter START_RC_CYC = `SWRC_START_RC_CYC,
   parameter START_STD_CYC = `SWRC_START_STD_CYC,
   parameter STACK_DEPTH = 4
)
(
   // Clock and power-on reset
   input wire clock_i,
   input wire rstn_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // External pins
   input wire [3:0] wake_pin_i,
   input wire wake_slow_pin_i,
   input wire master_clear_n_i,
   input wire brownout_3v1_i,
   input wire brownout_2v2_i,
   // Configuration fuses
   input wire wdt_fuse_i,
   input wire osc_select_hi_i,
   input wire osc_select_lo_i,
   // Core call stack
   input wire stk_push_i,
   input wire stk_pop_i,
   input wire [8:0] stk_addr_i,
   output reg [8:0] stk_top_o,
   // Outputs to core, regulator and pin
   output reg core_reset_o,
   output reg wdt_enable_o,
   output reg fuse_sense_en_o,
   output reg core_low_v_o,
   output reg clock_output_pin_o
);
   localparam ST_RUN = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_HOLD = 2'h2;
   localparam ST_START = 2'h3;

   // Synchronised and filtered pins, brown-out inputs synchronised only
   wire [5:0] raw_pins;
   wire [5:0] sync_pins;
   wire [5:0] filt_pins;
   wire bo_3v1_s;
   wire bo_2v2_s;
   // Clear pin enters inverted so its synchroniser idles at its reset value
   assign raw_pins = {~master_clear_n_i, wake_slow_pin_i, wake_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_pin
         swrc_sync u_sync
         (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .pin_i(raw_pins[gi]),
            .sync_o(sync_pins[gi])
         );
         swrc_filt #(.RST_VAL(1'b0)) u_filt
         (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .in_i(sync_pins[gi]),
            .out_o(filt_pins[gi])
         );
      end
   endgenerate

   swrc_sync u_bo3
   (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(brownout_3v1_i),
      .sync_o(bo_3v1_s)
   );
   swrc_sync u_bo2
   (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(brownout_2v2_i),
      .sync_o(bo_2v2_s)
   );

   // Registers
   reg [7:0] xcfg;
   reg [3:0] ctrl;
   reg [7:0] timer_zero;
   reg [9:0] presc;
   reg pin_change_wake_flag;
   reg [1:0] state;
   reg [4:0] wake_ref;
   reg wdt_latched;
   reg [31:0] start_cnt;
   reg [8:0] stack [0:STACK_DEPTH-1];
   reg [2:0] stk_cnt;

   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_xcfg = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SWRC_ADR_XCFG);
   wire wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SWRC_ADR_CTRL);
   wire wr_tmr = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SWRC_ADR_TMR);
   wire wr_stat = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SWRC_ADR_STAT);
   wire rc_mode = osc_select_hi_i & osc_select_lo_i;
   wire master_clear_n_act = filt_pins[5];
   // Trip select may only change while the detector is off
   wire bo_sel_locked = ~xcfg[`SWRC_XCFG_BO_EN_N];
   // Trip level selected by config bit, only when detector enabled
   wire bo_trip = ~xcfg[`SWRC_XCFG_BO_EN_N] &
      (xcfg[`SWRC_XCFG_BO_SEL3V] ? bo_2v2_s : bo_3v1_s);
   wire hold = master_clear_n_act | bo_trip;
   wire [4:0] wake_now = filt_pins[4:0];
   wire wake_hit = (state == ST_SLEEP) & xcfg[`SWRC_XCFG_WAKE_EN] &
      (wake_now != wake_ref);
   wire [31:0] start_len = rc_mode ? START_RC_CYC : START_STD_CYC;
   wire wdt_live = wdt_fuse_i | xcfg[`SWRC_XCFG_SWDT];

   // Prescaler tap: /4 at setting 0 up to /512 at setting 7
   wire [2:0] psel = ctrl[`SWRC_CTRL_PRESC];
   wire [9:0] tap_mask = (10'h004 << psel) - 10'h001;
   wire tmr_tick = (presc & tap_mask) == tap_mask;

   // Reset, sleep and start-up sequencing
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state <= ST_HOLD;
         start_cnt <= 32'h0;
         wake_ref <= 5'h00;
         wdt_latched <= 1'b0;
         pin_change_wake_flag <= 1'b1;
         core_reset_o <= 1'b1;
         fuse_sense_en_o <= 1'b1;
         core_low_v_o <= 1'b0;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (hold)
               begin
                  state <= ST_HOLD;
                  core_reset_o <= 1'b1;
               end
               else if (wr_ctrl & wb_dat_i[`SWRC_CTRL_SLEEP])
               begin
                  state <= ST_SLEEP;
                  wake_ref <= wake_now;
                  wdt_latched <= wdt_live;
                  fuse_sense_en_o <= 1'b0;
                  core_low_v_o <= xcfg[`SWRC_XCFG_SL];
               end
            end
            ST_SLEEP:
            begin
               if (hold | wake_hit)
               begin
                  state <= ST_HOLD;
                  core_reset_o <= 1'b1;
                  fuse_sense_en_o <= 1'b1;
                  core_low_v_o <= 1'b0;
                  if (wake_hit)
                  begin
                     pin_change_wake_flag <= 1'b0;
                  end
               end
            end
            ST_HOLD:
            begin
               if (!hold)
               begin
                  state <= ST_START;
                  start_cnt <= 32'h0;
               end
            end
            ST_START:
            begin
               if (hold)
               begin
                  state <= ST_HOLD;
               end
               else if (start_cnt >= start_len - 32'h1)
               begin
                  state <= ST_RUN;
                  core_reset_o <= 1'b0;
               end
               else
               begin
                  start_cnt <= start_cnt + 32'h1;
               end
            end
            default:
            begin
               state <= ST_HOLD;
            end
         endcase
         // Software sets the flag back by writing one to it, wake clear wins
         if (wr_stat & wb_dat_i[`SWRC_STAT_PIN_CHANGE_WAKE_FLAG] & ~wake_hit)
         begin
            pin_change_wake_flag <= 1'b1;
         end
      end
   end

   // Config, control, timer and clock output
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         xcfg <= `SWRC_XCFG_RST;
         ctrl <= `SWRC_CTRL_RST;
         timer_zero <= 8'h00;
         presc <= 10'h000;
         clock_output_pin_o <= 1'b0;
         wdt_enable_o <= 1'b0;
      end
      else
      begin
         if (wr_xcfg)
         begin
            xcfg <= wb_dat_i[7:0];
            if (bo_sel_locked)
            begin
               xcfg[`SWRC_XCFG_BO_SEL3V] <= xcfg[`SWRC_XCFG_BO_SEL3V];
            end
         end
         if (wr_ctrl)
         begin
            ctrl <= {wb_dat_i[3:1], 1'b0};
         end
         presc <= presc + 10'h001;
         if (wr_tmr)
         begin
            timer_zero <= wb_dat_i[7:0];
         end
         else if (tmr_tick)
         begin
            timer_zero <= timer_zero + 8'h01;
         end
         clock_output_pin_o <= rc_mode & timer_zero[0];
         wdt_enable_o <= (state == ST_SLEEP) ? wdt_latched : wdt_live;
      end
   end

   // Return-address stack, oldest entry lost on overflow
   integer si;
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (si = 0; si < STACK_DEPTH; si = si + 1)
         begin
            stack[si] <= 9'h000;
         end
         stk_cnt <= 3'h0;
         stk_top_o <= 9'h000;
      end
      else if (stk_push_i)
      begin
         for (si = STACK_DEPTH - 1; si > 0; si = si - 1)
         begin
            stack[si] <= stack[si-1];
         end
         stack[0] <= stk_addr_i;
         stk_top_o <= stk_addr_i;
         if (stk_cnt != STACK_DEPTH[2:0])
         begin
            stk_cnt <= stk_cnt + 3'h1;
         end
      end
      else if (stk_pop_i)
      begin
         // Popping an empty stack leaves the stale top in place
         if (stk_cnt != 3'h0)
         begin
            for (si = 0; si < STACK_DEPTH - 1; si = si + 1)
            begin
               stack[si] <= stack[si+1];
            end
            stk_top_o <= stack[1];
            stk_cnt <= stk_cnt - 3'h1;
         end
      end
   end

   // Wishbone read and ack
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_req & ~wb_we_i)
         begin
            case (wb_adr_i)
               `SWRC_ADR_XCFG: wb_dat_o <= {24'h0, xcfg};
               `SWRC_ADR_STAT: wb_dat_o <= {27'h0, bo_trip, wdt_enable_o,
                  core_reset_o, state == ST_SLEEP, pin_change_wake_flag};
               `SWRC_ADR_CTRL: wb_dat_o <= {28'h0, ctrl};
               `SWRC_ADR_TMR: wb_dat_o <= {24'h0, timer_zero};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
endmodule // swrc_top

/* test/swrc_pins.sv */
// External wake pins, reset switch and supply monitor
`timescale 1ns/1ps
module swrc_pins
(
   // Pin timing clock
   input wire logic clock_i,
   // Pins toward the block
   output logic [3:0] wake_pin_o,
   output logic wake_slow_pin_o,
   output logic master_clear_n_o,
   output logic brownout_3v1_o,
   output logic brownout_2v2_o
);
   logic [4:0] lvl;
   assign {wake_slow_pin_o, wake_pin_o} = lvl;
   initial
   begin
      lvl = 5'h00;
      master_clear_n_o = 1'b1;
      brownout_3v1_o = 1'b0;
      brownout_2v2_o = 1'b0;
   end
   task automatic flip(input logic [4:0] m);
      lvl <= lvl ^ m;
   endtask
   // Hold the reset switch closed for n cycles
   task automatic clear_pulse(input int n);
      master_clear_n_o <= 1'b0;
      repeat (n) @(posedge clock_i);
      master_clear_n_o <= 1'b1;
   endtask
   // 0 supply good, 1 below upper trip, 2 below both
   task automatic supply(input int s);
      brownout_3v1_o <= s > 0;
      brownout_2v2_o <= s > 1;
   endtask
endmodule // swrc_pins

/* test/swrc_top_chk.sv */
// Port assertions for the sleep, wake and reset block
`timescale 1ns/1ps
module swrc_chk
#(
   parameter START_RC_CYC = 20,
   parameter START_STD_CYC = 50
)
(
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Pins and fuses
   input wire master_clear_n_i,
   input wire wdt_fuse_i,
   input wire osc_select_hi_i,
   input wire osc_select_lo_i,
   // Stack
   input wire stk_push_i,
   input wire [8:0] stk_addr_i,
   input wire [8:0] stk_top_o,
   // Outputs
   input wire core_reset_o,
   input wire wdt_enable_o,
   input wire fuse_sense_en_o,
   input wire core_low_v_o,
   input wire clock_output_pin_o
);
   int hi_cnt;
   wire rc = osc_select_hi_i & osc_select_lo_i;
   always @(posedge clock_i or negedge rstn_i)
      if (!rstn_i)
         hi_cnt <= 0;
      else
         hi_cnt <= core_reset_o ? hi_cnt + 1 : 0;
   default clocking dc @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   a_clear_holds: assert property (!master_clear_n_i [*8] |-> ##[0:2] core_reset_o)
      else $error("clear did not reset");
   a_clear_glitch: assert property
      ((!core_reset_o && $fell(master_clear_n_i)) ##1 master_clear_n_i |=> !core_reset_o [*6])
      else $error("glitch reset core");
   a_fuse_wdt: assert property (wdt_fuse_i [*4] |-> wdt_enable_o)
      else $error("fuse wdt off");
   a_sleep_latch: assert property
      (!fuse_sense_en_o && !$past(fuse_sense_en_o) |-> $stable(wdt_enable_o))
      else $error("wdt moved in sleep");
   a_low_v_sleep: assert property (core_low_v_o |-> !fuse_sense_en_o)
      else $error("low voltage while awake");
   a_clock_output_pin_off: assert property (!rc |-> ##1 !clock_output_pin_o)
      else $error("clock out outside rc");
   a_start_len: assert property
      ($fell(core_reset_o) |-> hi_cnt >= (rc ? START_RC_CYC : START_STD_CYC))
      else $error("start-up too short");
   a_stack_push: assert property (stk_push_i |=> stk_top_o == $past(stk_addr_i))
      else $error("push lost");
   cover property ($fell(fuse_sense_en_o) ##[1:60] $rose(core_reset_o));
   cover property ($rose(clock_output_pin_o));
   cover property (stk_push_i);
endmodule // swrc_chk
bind swrc_top swrc_chk #(.START_RC_CYC(START_RC_CYC), .START_STD_CYC(START_STD_CYC)) chk
   (.clock_i, .rstn_i, .master_clear_n_i, .wdt_fuse_i, .osc_select_hi_i, .osc_select_lo_i,
   .stk_push_i, .stk_addr_i, .stk_top_o, .core_reset_o, .wdt_enable_o, .fuse_sense_en_o,
   .core_low_v_o, .clock_output_pin_o);

/* test/tb_sleep_wake_reset_control.sv */
// Self-checking bench for the sleep, wake and reset block
`timescale 1ns/1ps
module tb_sleep_wake_reset_control;
   logic clock_i, rstn_i, cyc, we, fuse, hi, lo, push, pop;
   logic ack, rst_o, wdt, fse, lowv, clko, bo3, bo2, mcn, slow;
   logic [3:0] adr, sel, wp;
   logic [8:0] sa, top, v[5];
   logic [31:0] dat, dat_o, expq[$];
   int err_count = 0, samples_checked = 0, seed = 34, n, i;
   always #2.5 clock_i = ~clock_i;
   swrc_top #(.START_RC_CYC(20), .START_STD_CYC(50)) dut (.clock_i, .rstn_i,
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wake_pin_i(wp),
      .wake_slow_pin_i(slow), .master_clear_n_i(mcn), .brownout_3v1_i(bo3),
      .brownout_2v2_i(bo2), .wdt_fuse_i(fuse), .osc_select_hi_i(hi), .osc_select_lo_i(lo),
      .stk_push_i(push), .stk_pop_i(pop), .stk_addr_i(sa), .stk_top_o(top),
      .core_reset_o(rst_o), .wdt_enable_o(wdt), .fuse_sense_en_o(fse),
      .core_low_v_o(lowv), .clock_output_pin_o(clko));
   swrc_pins pins (.clock_i, .wake_pin_o(wp), .wake_slow_pin_o(slow),
      .master_clear_n_o(mcn), .brownout_3v1_o(bo3), .brownout_2v2_o(bo2));
   task automatic wt(input int m);
      repeat (m) @(posedge clock_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   // Wait up to m cycles for reset (s=0) or clock out (s=1) to reach l
   task automatic wv(input int s, input logic l, input int m);
      while ((s ? clko : rst_o) !== l && m-- > 0)
      begin
         @(posedge clock_i);
         n++;
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do
         @(posedge clock_i);
      while (ack !== 1'b1);
      cyc <= 0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(0, a, 0);
   endtask
   always @(posedge clock_i)
      if (ack === 1'b1 && !we && expq.size() > 0)
         chk(dat_o, expq.pop_front());
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_count++;
      give_verdict();
   end
   initial
   begin
      clock_i = 1'b0;
      {rstn_i, cyc, we, fuse, push, pop} = 6'h00;
      {hi, lo} = 2'h3;
      adr = 4'h0;
      sel = 4'hf;
      sa = 9'h000;
      dat = 32'h0;
      wt(8);
      rstn_i <= 1;
      n = 0;
      wv(0, 0, 300);
      chk(n >= 20 && n < 50, 1);
      rd(4'h0, 32'h02);
      rd(4'h4, 32'h01);
      bus(1, 4'h1, 32'hff);
      rd(4'h1, 32'h00);
      sel <= 4'he;
      bus(1, 4'h0, 32'h12);
      sel <= 4'hf;
      rd(4'h0, 32'h02);
      bus(1, 4'h0, 32'h12);
      wt(2);
      chk(wdt, 1);
      bus(1, 4'h0, 32'h02);
      wt(2);
      chk(wdt, 0);
      pins.supply(1);
      wt(20);
      chk(rst_o, 0);
      bus(1, 4'h0, 32'h04);
      wt(20);
      chk(rst_o, 0);
      pins.supply(2);
      wv(0, 1, 20);
      wt(100);
      chk(rst_o, 1);
      pins.supply(0);
      wv(0, 0, 300);
      bus(1, 4'h0, 32'h00);
      rd(4'h0, 32'h04);
      bus(1, 4'h0, 32'h02);
      bus(1, 4'h0, 32'h00);
      pins.supply(1);
      wv(0, 1, 20);
      chk(rst_o, 1);
      pins.supply(0);
      wv(0, 0, 300);
      $display("brown-out ended");
      for (i = 0; i < 5; i++)
      begin
         pins.flip(5'($random(seed)));
         bus(1, 4'h0, 32'h0b);
         bus(1, 4'h4, 32'h01);
         rd(4'h4, 32'h01);
         pins.flip(5'h1f);
         wt(12);
         chk(rst_o, 0);
         bus(1, 4'h8, 32'h01);
         wt(2);
         chk({lowv, fse}, 2'b10);
         pins.flip(5'h1 << i);
         wt(1);
         pins.flip(5'h1 << i);
         wt(12);
         chk(rst_o, 0);
         pins.flip(5'h1 << i);
         wv(0, 1, 12);
         chk(rst_o, 1);
         wv(0, 0, 300);
         rd(4'h4, 32'h00);
      end
      bus(1, 4'h0, 32'h0a);
      bus(1, 4'h8, 32'h01);
      pins.flip(5'h1f);
      wt(12);
      chk(rst_o, 0);
      pins.clear_pulse(1);
      wt(12);
      chk(rst_o, 0);
      pins.clear_pulse(10);
      chk(rst_o, 1);
      wv(0, 0, 300);
      $display("wake ended");
      bus(1, 4'h8, 32'h0e);
      bus(1, 4'hc, 32'h01);
      chk(clko, 1);
      bus(1, 4'hc, 32'h00);
      chk(clko, 0);
      for (i = 0; i < 8; i++)
      begin
         bus(1, 4'h8, 32'(i << 1));
         wv(1, 0, 3000);
         wv(1, 1, 3000);
         n = 0;
         wv(1, 0, 3000);
         wv(1, 1, 3000);
         chk(n, 8 << i);
      end
      for (i = 0; i < 5; i++)
      begin
         v[i] = 9'($random(seed));
         sa <= v[i];
         push <= 1;
         wt(1);
         push <= 0;
         wt(1);
      end
      chk(top, v[4]);
      for (i = 3; i > 0; i--)
      begin
         pop <= 1;
         wt(1);
         pop <= 0;
         wt(1);
         chk(top, v[i]);
      end
      $display("clock and stack ended");
      rstn_i <= 0;
      fuse <= 1;
      hi <= 0;
      wt(8);
      rstn_i <= 1;
      n = 0;
      wv(0, 0, 300);
      chk(n >= 50 && n < 80, 1);
      bus(1, 4'hc, 32'h01);
      chk(clko, 0);
      bus(1, 4'h8, 32'h01);
      wt(2);
      chk({wdt, fse, lowv}, 3'b100);
      $display("fuse ended");
      give_verdict();
   end
endmodule // tb_sleep_wake_reset_control
